// ===== logic/mtrl_pkg.sv
// Constants for the memory type range lookup block
package mtrl_pkg;
    // Register select codes on the model-specific register port
    localparam logic [4:0] REG_CAP = 5'h00; // Read-only capability
    localparam logic [4:0] REG_DEF = 5'h01; // Default type and enables
    localparam logic [4:0] REG_FIX_FIRST = 5'h02; // First of eleven fixed registers
    localparam logic [4:0] REG_FIX_LAST = 5'h0c; // Last fixed register
    localparam logic [4:0] REG_VAR_FIRST = 5'h10; // Base 0, mask 0 at +1, base 1 at +2 ...
    localparam logic [4:0] REG_VAR_LAST = 5'h1f;
    localparam int FIX_COUNT = 11;
    localparam int VAR_COUNT = 8;
    // Capability value: eight pairs, fixed ranges, write combining
    localparam logic [63:0] CAP_VALUE = 64'h0000_0000_0000_0508;
    // Default register fields
    localparam int DEF_FE_BIT = 10;
    localparam int DEF_E_BIT = 11;
    localparam logic [63:0] DEF_WRITABLE = 64'h0000_0000_0000_0cff;
    // Variable pair fields
    localparam int MASK_VALID_BIT = 11;
    localparam logic [63:0] BASE_WRITABLE = 64'h0000_000f_ffff_f0ff;
    localparam logic [63:0] MASK_WRITABLE = 64'h0000_000f_ffff_f800;
    // Memory type encodings
    localparam logic [7:0] MT_UNCACHEABLE = 8'h00;
    localparam logic [7:0] MT_WRITE_COMBINING = 8'h01;
    localparam logic [7:0] MT_WRITE_THROUGH = 8'h04;
    localparam logic [7:0] MT_WRITE_PROTECTED = 8'h05;
    localparam logic [7:0] MT_WRITE_BACK = 8'h06;
    // Region boundaries of the first megabyte (address bits 19:16)
    localparam logic [3:0] SEG_16K_START = 4'h8;
    localparam logic [3:0] SEG_4K_START = 4'hc;
endpackage

// ===== logic/mtrl_lookup.sv
// Memory type range lookup: range registers and physical address typing
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Capability low byte reports eight variable pairs
// - Capability bits 8, 10 read one
// - Capability reserved bits; any write faults
// - Capability always reads constant 508H
// - Default type accepts 0,1,4,5,6 only
// - Global enable clear makes everything uncacheable
// - Unmatched addresses take the default type
// - Fixed enable on; fixed beats variable
// - Fixed enable matters only under global enable
// - Nonzero reserved default bits raise fault
// - Eleven fixed registers, eight byte fields each
// - First fixed register: eight 64K sub-ranges
// - Two registers: sixteen 16K sub-ranges
// - Eight registers: sixty-four 4K sub-ranges
// - Eight variable base/mask pairs
// - Base holds type and 4K-aligned base
// - Hit when address&mask equals base&mask
// - Mask bit 11 validates the pair
// - Reserved base/mask bit writes fault
// - Uncacheable overlap resolves to uncacheable
// - Enabled fixed range overrides variable range
// - Mask-gap addresses take the pair's type
// - Type codes 00,01,04,05,06; rest reserved
// - Write-through with write-back gives write-through
// - Reset clears valid flags and global enable
module mtrl_lookup
    import mtrl_pkg::*;
#(
    parameter int PA_WIDTH = 36 // Physical address width
)(
    input wire logic mclk, // Core clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic reg_rd, // Register read strobe
    input wire logic reg_wr, // Register write strobe
    input wire logic [4:0] reg_sel, // Register select
    input wire logic [63:0] reg_wdata, // Write data
    output logic [63:0] reg_rdata, // Read data, registered
    output logic reg_ack, // Access done, one cycle after strobe
    output logic protection_fault, // Access refused, pulse with ack
    input wire logic lookup_req, // Address valid
    input wire logic [PA_WIDTH-1:0] lookup_addr, // Physical address
    output logic [7:0] lookup_type, // Resolved memory type, registered
    output logic lookup_valid // Result valid, one cycle after req
);
    import mtrl_pkg::*;

    // Register storage
    logic [63:0] def_q; // Default type control
    logic [63:0] fix_q [FIX_COUNT]; // Fixed-range type registers
    logic [63:0] base_q [VAR_COUNT]; // Variable range bases
    logic [63:0] mask_q [VAR_COUNT]; // Variable range masks
    // Answer and lookup result registers
    logic [63:0] reg_rdata_q;
    logic reg_ack_q;
    logic fault_q;
    logic [7:0] lookup_type_q;
    logic lookup_valid_q;

    // Access decode
    wire sel_cap = (reg_sel == REG_CAP);
    wire sel_def = (reg_sel == REG_DEF);
    wire sel_fix = (reg_sel >= REG_FIX_FIRST) && (reg_sel <= REG_FIX_LAST);
    wire sel_var = (reg_sel >= REG_VAR_FIRST);
    wire [3:0] fix_idx = 4'(reg_sel - REG_FIX_FIRST);
    wire [2:0] var_idx = reg_sel[3:1];
    wire var_is_mask = reg_sel[0];
    wire sel_none = !(sel_cap || sel_def || sel_fix || sel_var);

    // Legal type check, reserved codes refused
    function automatic logic type_ok(input logic [7:0] t);
        type_ok = (t == MT_UNCACHEABLE) || (t == MT_WRITE_COMBINING) ||
                  (t == MT_WRITE_THROUGH) || (t == MT_WRITE_PROTECTED) ||
                  (t == MT_WRITE_BACK);
    endfunction

    // Every byte lane of a fixed register must hold a legal code
    logic fix_types_ok;
    always_comb
    begin
        fix_types_ok = 1'b1;
        for (int b = 0; b < 8; b++)
            fix_types_ok = fix_types_ok && type_ok(reg_wdata[b*8 +: 8]);
    end

    // Write fault causes
    wire def_bad = |(reg_wdata & ~DEF_WRITABLE) || !type_ok(reg_wdata[7:0]);
    wire var_bad = var_is_mask ? |(reg_wdata & ~MASK_WRITABLE)
                 : (|(reg_wdata & ~BASE_WRITABLE) || !type_ok(reg_wdata[7:0]));
    wire wr_fault = reg_wr && (sel_cap || sel_none || (sel_def && def_bad) ||
                    (sel_fix && !fix_types_ok) || (sel_var && var_bad));
    wire rd_fault = reg_rd && !reg_wr && sel_none;
    wire wr_ok = reg_wr && !wr_fault;

    // Read mux
    logic [63:0] rd_mux;
    always_comb
    begin
        rd_mux = 64'h0;
        if (sel_cap)
            rd_mux = CAP_VALUE;
        else if (sel_def)
            rd_mux = def_q;
        else if (sel_fix)
            rd_mux = fix_q[fix_idx];
        else if (sel_var)
            rd_mux = var_is_mask ? mask_q[var_idx] : base_q[var_idx];
    end

    // Default register; enables cleared at reset, type bits also zeroed
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            def_q <= 64'h0;
        else if (wr_ok && sel_def)
            def_q <= reg_wdata;
    end

    // Fixed registers: reset to zero for determinism
    genvar gf;
    generate
        for (gf = 0; gf < FIX_COUNT; gf++)
        begin : g_fix
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                    fix_q[gf] <= 64'h0;
                else if (wr_ok && sel_fix && (fix_idx == 4'(gf)))
                    fix_q[gf] <= reg_wdata;
            end
        end
    endgenerate

    // Variable pairs; valid flag cleared at reset
    genvar gv;
    generate
        for (gv = 0; gv < VAR_COUNT; gv++)
        begin : g_var
            always_ff @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    base_q[gv] <= 64'h0;
                    mask_q[gv] <= 64'h0;
                end
                else if (wr_ok && sel_var && (var_idx == 3'(gv)))
                begin
                    if (var_is_mask)
                        mask_q[gv] <= reg_wdata;
                    else
                        base_q[gv] <= reg_wdata;
                end
            end
        end
    endgenerate

    // Register port answer
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata_q <= 64'h0;
            reg_ack_q <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            reg_ack_q <= reg_rd || reg_wr;
            fault_q <= wr_fault || rd_fault;
            // Zero after writes and refusals, so a stale word never looks valid
            reg_rdata_q <= (reg_rd && !reg_wr && !sel_none) ? rd_mux : 64'h0;
        end
    end

    // Fixed-range selection by address
    // Upper address bits only gate the hit; bits 19:12 pick register and lane
    wire global_en = def_q[DEF_E_BIT];
    wire fixed_en = def_q[DEF_FE_BIT];
    wire below_1m = ~|lookup_addr[PA_WIDTH-1:20];
    wire [3:0] a_seg = lookup_addr[19:16];
    logic [3:0] fix_reg;
    logic [2:0] fix_lane;
    always_comb
    begin
        if (a_seg < SEG_16K_START)
        begin
            fix_reg = 4'd0;
            fix_lane = lookup_addr[18:16];
        end
        else if (a_seg < SEG_4K_START)
        begin
            fix_reg = 4'd1 + {3'd0, lookup_addr[17]};
            fix_lane = lookup_addr[16:14];
        end
        else
        begin
            fix_reg = 4'd3 + {1'b0, lookup_addr[17:15]};
            fix_lane = lookup_addr[14:12];
        end
    end
    wire [63:0] fix_word = fix_q[fix_reg];
    wire [7:0] fix_type = fix_word[{fix_lane, 3'b000} +: 8];
    wire fix_hit = global_en && fixed_en && below_1m;

    // Variable range matching
    // Gapped masks are not refused; they simply match more addresses
    logic [VAR_COUNT-1:0] pair_valid; // Valid flag of each pair
    logic [VAR_COUNT-1:0] var_hit;
    genvar gm;
    generate
        for (gm = 0; gm < VAR_COUNT; gm++)
        begin : g_match
            wire [PA_WIDTH-1:0] m = {mask_q[gm][PA_WIDTH-1:12], 12'h000};
            wire [PA_WIDTH-1:0] b = {base_q[gm][PA_WIDTH-1:12], 12'h000};
            assign pair_valid[gm] = mask_q[gm][MASK_VALID_BIT];
            assign var_hit[gm] = pair_valid[gm] &&
                                 ((lookup_addr & m) == (b & m));
        end
    endgenerate

    // Overlap resolution: uncacheable first, then write-through over write-back
    // Undefined mixes take the lowest-index hit; cheaper than a fault path
    logic any_var;
    logic any_uc;
    logic any_wt;
    logic [7:0] first_type;
    always_comb
    begin
        any_var = 1'b0;
        any_uc = 1'b0;
        any_wt = 1'b0;
        first_type = MT_UNCACHEABLE;
        for (int i = VAR_COUNT - 1; i >= 0; i--)
        begin
            if (var_hit[i])
            begin
                any_var = 1'b1;
                first_type = base_q[i][7:0];
                if (base_q[i][7:0] == MT_UNCACHEABLE)
                    any_uc = 1'b1;
                if (base_q[i][7:0] == MT_WRITE_THROUGH)
                    any_wt = 1'b1;
            end
        end
    end

    // Final type priority
    logic [7:0] type_d;
    always_comb
    begin
        if (!global_en)
            type_d = MT_UNCACHEABLE;
        else if (fix_hit)
            type_d = fix_type;
        else if (any_uc)
            type_d = MT_UNCACHEABLE;
        else if (any_wt)
            type_d = MT_WRITE_THROUGH;
        else if (any_var)
            type_d = first_type;
        else
            type_d = def_q[7:0];
    end

    // Lookup result register
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            lookup_type_q <= MT_UNCACHEABLE;
            lookup_valid_q <= 1'b0;
        end
        else
        begin
            lookup_valid_q <= lookup_req;
            lookup_type_q <= type_d;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign reg_ack = reg_ack_q;
    assign protection_fault = fault_q;
    assign lookup_type = lookup_type_q;
    assign lookup_valid = lookup_valid_q;

    // Assertions, sampled on the core clock and idle during reset
    // Legal default write: accepted and stored in one cycle
    sequence s_def_write_ok;
        reg_wr && sel_def && !def_bad;
    endsequence
    // A write-through pair hits with no uncacheable hit and no fixed hit
    sequence s_wt_over_wb;
        lookup_req && global_en && !fix_hit && !any_uc && any_wt;
    endsequence
    // Fixed ranges off, an uncacheable pair covers the address
    sequence s_low_var_uc;
        lookup_req && global_en && !fixed_en && any_uc;
    endsequence

    // Capability register
    // Whole word is the constant
    a_cap_constant: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_rd && !reg_wr && sel_cap) |=> (reg_rdata == 64'h508))
        else $error("capability read wrong");
    // Pair count and feature flags
    a_cap_fields: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_rd && !reg_wr && sel_cap)
        |=> (reg_rdata[7:0] == 8'(VAR_COUNT) && reg_rdata[8] && reg_rdata[10]))
        else $error("capability fields wrong");
    // Any write is refused
    a_cap_write_fault: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_wr && sel_cap) |=> protection_fault)
        else $error("capability write not refused");

    // Default register
    // Reserved type codes 02, 03, 07 refused, register untouched
    a_def_type_legal: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_wr && sel_def && reg_wdata[7:0] inside {8'h02, 8'h03, 8'h07})
        |=> (protection_fault && $stable(def_q)))
        else $error("illegal default type accepted");
    // Legal words land whole and raise no fault
    a_def_accept: assert property (@(posedge mclk) disable iff (!resetn)
        s_def_write_ok |=> (!protection_fault && def_q == $past(reg_wdata)))
        else $error("legal default write refused");
    // Reserved low flags refused
    a_def_resv_fault: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_wr && sel_def && |reg_wdata[9:8]) |=> protection_fault)
        else $error("reserved default bits accepted");

    // Lookup typing
    // Global enable clear forces uncacheable
    a_disabled_uc: assert property (@(posedge mclk) disable iff (!resetn)
        (lookup_req && !def_q[11]) |=> (lookup_valid && lookup_type == 8'h00))
        else $error("disabled lookup not uncacheable");
    // No hit falls to the default type
    a_default_used: assert property (@(posedge mclk) disable iff (!resetn)
        (lookup_req && def_q[11] && !fix_hit && var_hit == '0)
        |=> (lookup_type == $past(def_q[7:0])))
        else $error("default type not used");
    // Enabled fixed range wins in the first megabyte
    a_fixed_wins: assert property (@(posedge mclk) disable iff (!resetn)
        (lookup_req && def_q[11] && def_q[10] && lookup_addr < 36'h100000)
        |=> (lookup_type == $past(fix_type)))
        else $error("fixed type not used");
    // Variable ranges still apply with fixed ranges off
    a_fix_off_var: assert property (@(posedge mclk) disable iff (!resetn)
        s_low_var_uc |=> (lookup_type == MT_UNCACHEABLE))
        else $error("variable range lost with fixed ranges off");
    // Uncacheable beats any other pair
    a_uc_overlap: assert property (@(posedge mclk) disable iff (!resetn)
        (lookup_req && def_q[11] && !fix_hit && any_uc) |=> (lookup_type == 8'h00))
        else $error("uncacheable overlap lost");
    // Write-through beats write-back
    a_wt_over_wb: assert property (@(posedge mclk) disable iff (!resetn)
        s_wt_over_wb |=> (lookup_type == MT_WRITE_THROUGH))
        else $error("write-through overlap lost");
    // A pair without its valid flag never matches
    a_pair_valid: assert property (@(posedge mclk) disable iff (!resetn)
        (var_hit & ~pair_valid) == '0)
        else $error("invalid pair matched");

    // Range register writes and reset
    // Any reserved byte in a fixed write is refused
    a_fix_bad_type: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_wr && sel_fix && !fix_types_ok) |=> protection_fault)
        else $error("reserved fixed type accepted");
    // Reserved low mask bits 10:0 refused
    a_var_resv_fault: assert property (@(posedge mclk) disable iff (!resetn)
        (reg_wr && sel_var && var_is_mask && |reg_wdata[10:0]) |=> protection_fault)
        else $error("reserved mask bits accepted");
    // Release from reset finds all ranges disabled
    a_reset_clears: assert property (@(posedge mclk)
        $rose(resetn) |-> (!def_q[DEF_E_BIT] && pair_valid == '0))
        else $error("reset left ranges enabled");
endmodule
`default_nettype wire

// ===== tb/mtrl_core_model.sv
// Core-side model: issues register accesses and physical address lookups
`timescale 1ns/1ps
`default_nettype none
module mtrl_core_model (
    input wire logic mclk,
    output logic reg_rd,
    output logic reg_wr,
    output logic [4:0] reg_sel,
    output logic [63:0] reg_wdata,
    input wire logic [63:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic protection_fault,
    output logic lookup_req,
    output logic [35:0] lookup_addr,
    input wire logic [7:0] lookup_type,
    input wire logic lookup_valid
);
    // Idle levels from time zero
    initial
    begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_sel = 5'h00;
        reg_wdata = 64'h0;
        lookup_req = 1'b0;
        lookup_addr = 36'h0;
    end
    // One access: a single-cycle strobe, answer taken a cycle later
    task automatic rw(input logic w, input logic [4:0] s, input logic [63:0] d,
        output logic [63:0] rd, output logic ack, output logic flt);
        @(negedge mclk);
        reg_wr = w;
        reg_rd = ~w;
        reg_sel = s;
        reg_wdata = d;
        // Answer stands only in the cycle after the strobe edge
        @(negedge mclk);
        rd = reg_rdata;
        ack = reg_ack;
        flt = protection_fault;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released data is scrambled so stale words cannot pass
        reg_wdata = ~d;
    endtask
    // One lookup, result expected one cycle after the request
    task automatic look(input logic [35:0] ad, output logic [7:0] t, output logic v);
        @(negedge mclk);
        lookup_req = 1'b1;
        lookup_addr = ad;
        // Result stands only in the cycle after the request edge
        @(negedge mclk);
        t = lookup_type;
        v = lookup_valid;
        lookup_req = 1'b0;
        lookup_addr = ~ad;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the memory type range lookup
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mtrl_pkg::*;
    localparam logic [63:0] PAT = 64'h0605_0401_0006_0504; // All lanes legal codes
    logic mclk = 1'b0;
    logic resetn = 1'b0; // Held low for the first 16 cycles
    wire logic rd, wr, ack, flt, req, vld;
    wire logic [4:0] sel;
    wire logic [63:0] wd, rdat;
    wire logic [35:0] addr;
    wire logic [7:0] typ;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [63:0] r, p;
    logic a, f, v;
    logic [7:0] t;
    // 25 MHz core clock
    always #20 mclk = ~mclk;
    mtrl_lookup #(.PA_WIDTH(36)) mtrl_lookup_inst (.mclk(mclk), .resetn(resetn),
        .reg_rd(rd), .reg_wr(wr), .reg_sel(sel), .reg_wdata(wd), .reg_rdata(rdat),
        .reg_ack(ack), .protection_fault(flt), .lookup_req(req),
        .lookup_addr(addr), .lookup_type(typ), .lookup_valid(vld));
    mtrl_core_model mtrl_core_model_inst (.mclk(mclk), .reg_rd(rd), .reg_wr(wr),
        .reg_sel(sel), .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack),
        .protection_fault(flt), .lookup_req(req), .lookup_addr(addr),
        .lookup_type(typ), .lookup_valid(vld));
    // Compare tasks, one per kind of result
    task automatic chk_reg(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_typ(input logic [7:0] g, input logic [7:0] e);
        chk_reg({56'h0, g}, {56'h0, e});
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_reg({63'h0, g}, {63'h0, e});
    endtask
    // Write, read and lookup wrappers with their checks
    task automatic wrc(input logic [4:0] s, input logic [63:0] d, input logic ef);
        mtrl_core_model_inst.rw(1'b1, s, d, r, a, f);
        chk_bit(a, 1'b1);
        chk_bit(f, ef);
    endtask
    task automatic rdc(input logic [4:0] s, input logic [63:0] e, input logic ef);
        mtrl_core_model_inst.rw(1'b0, s, 64'h0, r, a, f);
        chk_bit(a, 1'b1);
        chk_bit(f, ef);
        chk_reg(r, e);
    endtask
    task automatic lk(input logic [35:0] ad, input logic [7:0] e);
        mtrl_core_model_inst.look(ad, t, v);
        chk_bit(v, 1'b1);
        chk_typ(t, e);
    endtask
    // Pattern for fixed register k: rotated by k bytes below 8; register 8 matches register 0, registers 9 and 10 get zero top bytes
    function automatic logic [63:0] fx(input int k);
        logic [127:0] w;
        w = {PAT, PAT} >> (8 * k);
        return w[63:0];
    endfunction
    // Start address of sub-range j of fixed register k
    function automatic logic [35:0] fa(input int k, input int j);
        if (k == 0)
            return 36'(j) * 36'h10000;
        if (k < 3)
            return 36'h80000 + 36'(k - 1) * 36'h20000 + 36'(j) * 36'h4000;
        return 36'hc0000 + 36'(k - 3) * 36'h8000 + 36'(j) * 36'h1000;
    endfunction
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard: the full run needs well under 2000 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            give_verdict();
        end
    end
    // Main sequence
    initial
    begin
        repeat (16) @(negedge mclk);
        resetn = 1'b1;
        rdc(REG_CAP, 64'h508, 1'b0);
        wrc(REG_CAP, 64'h0, 1'b1);
        rdc(REG_CAP, 64'h508, 1'b0);
        rdc(REG_DEF, 64'h0, 1'b0);
        rdc(5'h11, 64'h0, 1'b0);
        for (int c = 0; c < 8; c++)
            wrc(REG_DEF, 64'(c), !(c inside {0, 1, 4, 5, 6}));
        wrc(REG_DEF, 64'hff, 1'b1);
        for (int b = 0; b < 64; b++)
            if (b inside {8, 9, 12, 40, 63})
                wrc(REG_DEF, 64'h1 << b, 1'b1);
        wrc(REG_DEF, 64'hc05, 1'b0);
        rdc(REG_DEF, 64'hc05, 1'b0);
        for (int k = 0; k < 11; k++)
            wrc(5'(k + 2), fx(k), 1'b0);
        wrc(5'h02, 64'h0200, 1'b1);
        for (int k = 0; k < 11; k++)
        begin
            p = fx(k);
            rdc(5'(k + 2), p, 1'b0);
            for (int j = 0; j < 8; j++)
            begin
                lk(fa(k, j), p[8*j +: 8]);
                lk(fa(k, j + 1) - 36'h1, p[8*j +: 8]);
            end
        end
        // Uncacheable range over the first 16 MB
        wrc(5'h10, 64'h0, 1'b0);
        wrc(5'h11, 64'hf_ff00_0800, 1'b0);
        lk(36'h0, 8'h04);
        lk(36'h100000, MT_UNCACHEABLE);
        lk(36'h2000000, 8'h05);
        // Overlaps: uncacheable with write-back, write-through with write-back
        wrc(5'h12, 64'h10_0006, 1'b0);
        wrc(5'h13, 64'hf_fff0_0800, 1'b0);
        lk(36'h150000, 8'h00);
        wrc(5'h14, 64'h300_0004, 1'b0);
        wrc(5'h15, 64'hf_ff00_0800, 1'b0);
        wrc(5'h16, 64'h300_0006, 1'b0);
        wrc(5'h17, 64'hf_fff0_0800, 1'b0);
        lk(36'h3000000, 8'h04);
        lk(36'h3800000, 8'h04);
        wrc(5'h15, 64'hf_ff00_0000, 1'b0);
        lk(36'h3800000, 8'h05);
        // Discontinuous mask: bit 21 left out
        wrc(5'h18, 64'h500_0001, 1'b0);
        wrc(5'h19, 64'hf_ffdf_f800, 1'b0);
        lk(36'h5200000, 8'h01);
        lk(36'h5100000, 8'h05);
        // Reserved bits and unmapped selects
        wrc(5'h10, 64'h100, 1'b1);
        wrc(5'h10, 64'h7, 1'b1);
        wrc(5'h11, 64'hf_ff00_0801, 1'b1);
        wrc(5'h10, 64'h10_0000_0000, 1'b1);
        rdc(5'h10, 64'h0, 1'b0);
        rdc(5'h12, 64'h10_0006, 1'b0);
        rdc(5'h0d, 64'h0, 1'b1);
        wrc(5'h0e, 64'h0, 1'b1);
        // Enables: global off, then fixed off
        wrc(REG_DEF, 64'h406, 1'b0);
        lk(36'h10000, 8'h00);
        lk(36'h2000000, 8'h00);
        wrc(REG_DEF, 64'h806, 1'b0);
        lk(36'h10000, 8'h00);
        lk(36'h2000000, 8'h06);
        // Reset in mid-run
        @(negedge mclk);
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        rdc(REG_DEF, 64'h0, 1'b0);
        rdc(5'h11, 64'h0, 1'b0);
        lk(36'h100000, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
